// [design/mcs_pkg.sv]
// constants shared by the master clock select and gating block
// assumes a single 200 MHz system clock; every clock source arrives as a one-cycle tick
package mcs_pkg;

  // ************************************************************
  // register offsets (byte addresses)
  // ************************************************************
  localparam logic [7:0] SYS_CLOCK_SET_REG_OFF    = 8'h00;
  localparam logic [7:0] SYS_CLOCK_CLEAR_REG_OFF  = 8'h04;
  localparam logic [7:0] SYS_CLOCK_STATE_REG_OFF  = 8'h08;
  localparam logic [7:0] PERIPH_CLOCK_SET_REG_OFF = 8'h10;
  localparam logic [7:0] PERIPH_CLOCK_CLR_REG_OFF = 8'h14;
  localparam logic [7:0] PERIPH_CLOCK_ST_REG_OFF  = 8'h18;
  localparam logic [7:0] PLL_A_CONFIG_OFF         = 8'h28;
  localparam logic [7:0] PLL_B_CONFIG_OFF         = 8'h2c;
  localparam logic [7:0] MASTER_CLOCK_CONFIG_OFF  = 8'h30;
  localparam logic [7:0] PROG_OUTPUT_CONFIG0_OFF  = 8'h40;
  localparam logic [7:0] PROG_OUTPUT_CONFIG1_OFF  = 8'h44;
  localparam logic [7:0] POWER_STATUS_REG_OFF     = 8'h68;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int SRC_SEL_LSB    = 0;  // source_select_field [1:0]
  localparam int PRESCALE_LSB   = 2;  // prescale_field [4:2]
  localparam int PROC_RATIO_LSB = 8;  // processor_ratio_field [9:8]
  localparam int SETTLE_LSB     = 8;  // pll_settle_count [13:8]
  localparam int MULT_LSB       = 16; // pll multiplier [26:16], zero = off
  localparam int PROG_EN_LSB    = 8;  // prog output enables [9:8]
  localparam int PLL_A_LOCK_BIT = 1;
  localparam int PLL_B_LOCK_BIT = 2;
  localparam int MASTER_RDY_BIT = 3;
  localparam int PROG_RDY_LSB   = 8;
  localparam int PROC_CLK_BIT   = 0;

  // ************************************************************
  // reset values and timing
  // ************************************************************
  localparam logic [31:0] PLL_CONFIG_RESET = 32'h0000_3f00;
  localparam logic [2:0]  PRESCALE_MAX     = 3'h6;  // divide by 64
  localparam logic [1:0]  RATIO_MAX        = 2'h2;  // divide by 4
  localparam logic [1:0]  SYNC_SLOW_TICKS  = 2'h2;  // slow ticks to quiesce old source

  typedef enum logic [1:0] {
    MCS_SRC_SLOW,
    MCS_SRC_MAIN,
    MCS_SRC_PLL_A,
    MCS_SRC_PLL_B
  } mcs_src_e;

endpackage

// [design/mcs_divider.sv]
// power-of-two tick divider: one output tick per 2**ratio source ticks, ratio capped at PRESCALE_MAX
// assumes src_tick is a one-cycle enable on the system clock
`timescale 1ns/1ps
module mcs_divider #(
  parameter int CW = 6
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       clr,
  input  wire logic       src_tick,
  input  wire logic [2:0] ratio,
  output logic            tick_q
);
  import mcs_pkg::*;

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] last;
  logic [2:0]    r;

  always_comb begin
    r    = (ratio > PRESCALE_MAX) ? PRESCALE_MAX : ratio;
    last = CW'((7'h01 << r) - 7'h01);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else if (clr) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    // a count left above a lowered limit wraps at once instead of running to the top
    end else if (src_tick && cnt_q >= last) begin
      cnt_q  <= '0;
      tick_q <= 1'b1;
    end else begin
      if (src_tick) begin
        cnt_q <= cnt_q + 1'b1;
      end
      tick_q <= 1'b0;
    end
  end
endmodule

// [design/mcs_top.sv]
// master clock select, prescale, programmable outputs and peripheral gating
// assumes APB master on CLK; clock sources are one-cycle ticks synchronous to CLK
//
// Notes on behaviour
// - master source selectable, slow after reset
// - master prescaler 1 to 64, default 1
// - master is processor divided 1,2,4
// - master ready flag set when valid
// - source/prescale change clears ready until usable
// - selected PLL unlocked holds ready low
// - PLL A unlocked uses slow, B main
// - two outputs, set/clear enables, status
// - output source main/slow/PLL A/B
// - output prescaler 1 to 64, default 1
// - output ready after configured and enabled
// - output config taken in one write
// - seventeen peripheral clocks set/clear/status
// - peripheral clock equals master clock
// - prescaler adds up to 64 ticks
// - switch latency bounded by slow ticks
// - PLL switch includes settle count
// - settle count slow ticks before lock
// - peripherals off at reset, stop immediately
`timescale 1ns/1ps
module mcs_top #(
  parameter int NPERIPH = 17,
  parameter int NPROG   = 2
) (
  input  wire logic               CLK,
  input  wire logic               RSTN,
  input  wire logic               PSEL,
  input  wire logic               PENABLE,
  input  wire logic               PWRITE,
  input  wire logic [7:0]         PADDR,
  input  wire logic [31:0]        PWDATA,
  output logic [31:0]             PRDATA,
  output logic                    PREADY,
  output logic                    PSLVERR,
  input  wire logic               SLOW_TICK,
  input  wire logic               MAIN_TICK,
  input  wire logic               PLL_A_TICK,
  input  wire logic               PLL_B_TICK,
  output logic                    MASTER_TICK,
  output logic                    PROC_TICK,
  output logic [NPROG-1:0]        PROG_OUT_TICK,
  output logic [NPERIPH-1:0]      PERIPH_TICK
);
  import mcs_pkg::*;

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic tick_of(input logic [1:0] sel, input logic [3:0] ticks);
    tick_of = ticks[sel];
  endfunction

  function automatic logic [1:0] fallback(input logic [1:0] sel, input logic la, input logic lb);
    fallback = sel;
    if (sel == MCS_SRC_PLL_A && !la) begin
      fallback = MCS_SRC_SLOW;
    end else if (sel == MCS_SRC_PLL_B && !lb) begin
      fallback = MCS_SRC_MAIN;
    end
  endfunction

  typedef enum logic [1:0] {ST_RUN, ST_SYNC, ST_ARM} mcs_sw_e;

  logic [3:0]         ticks;
  logic               wr_en;
  logic               acc;
  logic [1:0]         src_sel_q;
  logic [2:0]         prescale_q;
  logic [1:0]         ratio_q;
  logic               mrdy_q;
  mcs_sw_e            sw_q;
  logic [1:0]         sync_cnt_q;
  logic [1:0]         eff_sel;
  logic               m_src;
  logic               proc_raw;
  logic               mck_raw;
  logic               sel_unlocked;
  logic               mckr_change;
  logic [31:0]        pll_cfg_q [2];
  logic [1:0]         lock_q;
  logic [1:0]         pend_q;
  logic [5:0]         settle_q [2];
  logic [4:0]         pck_cfg_q [NPROG];
  logic [NPROG-1:0]   pck_en_q;
  logic [NPROG-1:0]   pck_rdy_q;
  logic [NPROG-1:0]   pck_raw;
  logic [NPROG-1:0]   pck_wr;
  logic [NPERIPH-1:0] per_en_q;
  logic [31:0]        rd_d;
  logic               err_d;

  assign ticks = {PLL_B_TICK, PLL_A_TICK, MAIN_TICK, SLOW_TICK};
  assign acc   = PSEL && PENABLE && PREADY;
  assign wr_en = acc && PWRITE;

  // ************************************************************
  // apb slave: one wait state, answer registered
  // ************************************************************
  always_comb begin
    rd_d  = 32'h0000_0000;
    err_d = 1'b0;
    unique case (PADDR)
      SYS_CLOCK_SET_REG_OFF, SYS_CLOCK_CLEAR_REG_OFF,
      PERIPH_CLOCK_SET_REG_OFF, PERIPH_CLOCK_CLR_REG_OFF: rd_d = 32'h0000_0000;
      SYS_CLOCK_STATE_REG_OFF: begin
        rd_d[PROC_CLK_BIT]                        = 1'b1;
        rd_d[PROG_EN_LSB +: NPROG]                = pck_en_q;
      end
      PERIPH_CLOCK_ST_REG_OFF: rd_d[NPERIPH-1:0] = per_en_q;
      PLL_A_CONFIG_OFF:        rd_d = pll_cfg_q[0];
      PLL_B_CONFIG_OFF:        rd_d = pll_cfg_q[1];
      MASTER_CLOCK_CONFIG_OFF: begin
        rd_d[SRC_SEL_LSB +: 2]    = src_sel_q;
        rd_d[PRESCALE_LSB +: 3]   = prescale_q;
        rd_d[PROC_RATIO_LSB +: 2] = ratio_q;
      end
      PROG_OUTPUT_CONFIG0_OFF: rd_d[4:0] = pck_cfg_q[0];
      PROG_OUTPUT_CONFIG1_OFF: rd_d[4:0] = pck_cfg_q[NPROG-1];
      POWER_STATUS_REG_OFF: begin
        rd_d[PLL_A_LOCK_BIT]          = lock_q[0];
        rd_d[PLL_B_LOCK_BIT]          = lock_q[1];
        rd_d[MASTER_RDY_BIT]          = mrdy_q;
        rd_d[PROG_RDY_LSB +: NPROG]   = pck_rdy_q;
      end
      default: err_d = 1'b1;
    endcase
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else if (PSEL && PENABLE && !PREADY) begin
      PREADY  <= 1'b1;
      PRDATA  <= PWRITE ? 32'h0000_0000 : rd_d;
      PSLVERR <= err_d;
    end else begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end
  end

  // ************************************************************
  // pll lock model
  // ************************************************************
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      for (int i = 0; i < 2; i++) begin
        pll_cfg_q[i] <= PLL_CONFIG_RESET;
        settle_q[i]  <= PLL_CONFIG_RESET[SETTLE_LSB +: 6];
      end
      lock_q <= 2'b00;
      pend_q <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (wr_en && PADDR == (i == 0 ? PLL_A_CONFIG_OFF : PLL_B_CONFIG_OFF)) begin
          pll_cfg_q[i] <= PWDATA;
          settle_q[i]  <= PWDATA[SETTLE_LSB +: 6];
          lock_q[i]    <= 1'b0;
          pend_q[i]    <= (PWDATA[MULT_LSB +: 11] != 11'h000);
        end else if (pend_q[i] && settle_q[i] == 6'h00) begin
          lock_q[i] <= 1'b1;
          pend_q[i] <= 1'b0;
        end else if (pend_q[i] && SLOW_TICK) begin
          settle_q[i] <= settle_q[i] - 6'h01;
        end
      end
    end
  end

  // ************************************************************
  // master clock configuration and switch sequencer
  // ************************************************************
  assign mckr_change  = wr_en && PADDR == MASTER_CLOCK_CONFIG_OFF &&
                        (PWDATA[SRC_SEL_LSB +: 2] != src_sel_q || PWDATA[PRESCALE_LSB +: 3] != prescale_q);
  assign eff_sel      = fallback(src_sel_q, lock_q[0], lock_q[1]);
  assign sel_unlocked = (src_sel_q == MCS_SRC_PLL_A && !lock_q[0]) || (src_sel_q == MCS_SRC_PLL_B && !lock_q[1]);
  assign m_src        = (sw_q == ST_RUN) && tick_of(eff_sel, ticks);

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      src_sel_q  <= MCS_SRC_SLOW;
      prescale_q <= 3'h0;
      ratio_q    <= 2'h0;
    end else if (wr_en && PADDR == MASTER_CLOCK_CONFIG_OFF) begin
      src_sel_q  <= PWDATA[SRC_SEL_LSB +: 2];
      prescale_q <= PWDATA[PRESCALE_LSB +: 3];
      ratio_q    <= PWDATA[PROC_RATIO_LSB +: 2];
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      sw_q       <= ST_RUN;
      sync_cnt_q <= 2'h0;
    end else if (mckr_change) begin
      sw_q       <= ST_SYNC;
      sync_cnt_q <= 2'h0;
    end else begin
      unique case (sw_q)
        ST_RUN: sw_q <= ST_RUN;
        ST_SYNC: begin
          if (SLOW_TICK) begin
            sync_cnt_q <= sync_cnt_q + 2'h1;
            if (sync_cnt_q == SYNC_SLOW_TICKS - 2'h1) begin
              sw_q <= ST_ARM;
            end
          end
        end
        ST_ARM: begin
          if (tick_of(eff_sel, ticks)) begin
            sw_q <= ST_RUN;
          end
        end
        default: sw_q <= ST_RUN;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      mrdy_q <= 1'b1;
    end else begin
      mrdy_q <= !mckr_change && sw_q == ST_RUN && !sel_unlocked;
    end
  end

  mcs_divider u_proc_div (
    .clk      (CLK),
    .rst_n    (RSTN),
    .clr      (sw_q != ST_RUN),
    .src_tick (m_src),
    .ratio    (prescale_q),
    .tick_q   (proc_raw)
  );

  mcs_divider u_mck_div (
    .clk      (CLK),
    .rst_n    (RSTN),
    .clr      (sw_q != ST_RUN),
    .src_tick (proc_raw),
    .ratio    ({1'b0, (ratio_q > RATIO_MAX) ? RATIO_MAX : ratio_q}),
    .tick_q   (mck_raw)
  );

  // ************************************************************
  // programmable clock outputs
  // ************************************************************
  always_comb begin
    pck_wr[0] = wr_en && PADDR == PROG_OUTPUT_CONFIG0_OFF;
    pck_wr[NPROG-1] = wr_en && PADDR == PROG_OUTPUT_CONFIG1_OFF;
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      for (int i = 0; i < NPROG; i++) begin
        pck_cfg_q[i] <= {3'h0, MCS_SRC_SLOW};
      end
      pck_en_q  <= '0;
      pck_rdy_q <= '0;
    end else begin
      for (int i = 0; i < NPROG; i++) begin
        if (pck_wr[i]) begin
          pck_cfg_q[i] <= PWDATA[4:0];
        end
        if (wr_en && PADDR == SYS_CLOCK_CLEAR_REG_OFF && PWDATA[PROG_EN_LSB + i]) begin
          pck_en_q[i] <= 1'b0;
        end else if (wr_en && PADDR == SYS_CLOCK_SET_REG_OFF && PWDATA[PROG_EN_LSB + i]) begin
          pck_en_q[i] <= 1'b1;
        end
        if (pck_raw[i] && pck_en_q[i]) begin
          pck_rdy_q[i] <= 1'b1;
        end else if (pck_wr[i] || !pck_en_q[i]) begin
          pck_rdy_q[i] <= 1'b0;
        end
      end
    end
  end

  for (genvar g = 0; g < NPROG; g++) begin : g_prog
    mcs_divider u_pck_div (
      .clk      (CLK),
      .rst_n    (RSTN),
      .clr      (!pck_en_q[g] || pck_wr[g]),
      .src_tick (tick_of(pck_cfg_q[g][1:0], ticks)),
      .ratio    (pck_cfg_q[g][4:2]),
      .tick_q   (pck_raw[g])
    );
  end

  // ************************************************************
  // peripheral gating and output registers
  // ************************************************************
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      per_en_q <= '0;
    end else if (wr_en && PADDR == PERIPH_CLOCK_CLR_REG_OFF) begin
      per_en_q <= per_en_q & ~PWDATA[NPERIPH-1:0];
    end else if (wr_en && PADDR == PERIPH_CLOCK_SET_REG_OFF) begin
      per_en_q <= per_en_q | PWDATA[NPERIPH-1:0];
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      MASTER_TICK   <= 1'b0;
      PROC_TICK     <= 1'b0;
      PROG_OUT_TICK <= '0;
      PERIPH_TICK   <= '0;
    end else begin
      MASTER_TICK   <= mck_raw;
      PROC_TICK     <= proc_raw;
      PROG_OUT_TICK <= pck_raw & pck_en_q;
      PERIPH_TICK   <= per_en_q & {NPERIPH{mck_raw}};
    end
  end
endmodule

// [testbench/mcs_top_sva.sv]
// checker for mcs_top: apb answer timing and tick relations
// assumes it is bound to mcs_top with the same parameters
`timescale 1ns/1ps
module mcs_top_sva
  import mcs_pkg::*;
#(
  parameter int NPERIPH = 17,
  parameter int NPROG   = 2
) (
  input wire logic               CLK,
  input wire logic               RSTN,
  input wire logic               PSEL,
  input wire logic               PENABLE,
  input wire logic               PWRITE,
  input wire logic [7:0]         PADDR,
  input wire logic [31:0]        PWDATA,
  input wire logic [31:0]        PRDATA,
  input wire logic               PREADY,
  input wire logic               PSLVERR,
  input wire logic               SLOW_TICK,
  input wire logic               MAIN_TICK,
  input wire logic               PLL_A_TICK,
  input wire logic               PLL_B_TICK,
  input wire logic               MASTER_TICK,
  input wire logic               PROC_TICK,
  input wire logic [NPROG-1:0]   PROG_OUT_TICK,
  input wire logic [NPERIPH-1:0] PERIPH_TICK
);
  // ********
  // helpers
  // ********
  logic wr_done;
  logic cfg_seen_q;
  assign wr_done = PSEL && PENABLE && PREADY && PWRITE;
  // master still on its reset source until the first config write
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      cfg_seen_q <= 1'b0;
    end else if (wr_done && PADDR == MASTER_CLOCK_CONFIG_OFF) begin
      cfg_seen_q <= 1'b1;
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  sequence s_wait;
    PSEL && PENABLE && !PREADY;
  endsequence
  sequence s_answer;
    PREADY ##1 !PREADY;
  endsequence
  AST_APB_ONE_WAIT: assert property (s_wait |=> s_answer)
    else $error("pready not after one wait cycle");
  AST_READY_IN_ACCESS: assert property (PREADY |-> PSEL && PENABLE && $past(PSEL && PENABLE))
    else $error("pready outside an access");
  AST_ERR_READS_ZERO: assert property (PREADY && PSLVERR |-> PRDATA == 32'h0)
    else $error("error answer with data");
  AST_PERIPH_IS_MASTER: assert property ((PERIPH_TICK & ~{NPERIPH{MASTER_TICK}}) == '0)
    else $error("peripheral tick without master tick");
  AST_PERIPH_STOPS: assert property (wr_done && PADDR == PERIPH_CLOCK_CLR_REG_OFF
    |-> ##2 (PERIPH_TICK & $past(PWDATA[NPERIPH-1:0], 2)) == '0)
    else $error("peripheral tick after disable");
  AST_PROG_STOPS: assert property (wr_done && PADDR == SYS_CLOCK_CLEAR_REG_OFF
    |-> ##2 (PROG_OUT_TICK & $past(PWDATA[PROG_EN_LSB +: NPROG], 2)) == '0)
    else $error("programmable tick after disable");
  AST_MASTER_FROM_PROC: assert property (MASTER_TICK |-> $past(PROC_TICK))
    else $error("master tick without processor tick");
  AST_SLOW_DEFAULT: assert property (!cfg_seen_q && PROC_TICK |-> $past(SLOW_TICK, 2))
    else $error("default clock not from slow source");
endmodule

bind mcs_top mcs_top_sva #(.NPERIPH(NPERIPH), .NPROG(NPROG)) i_sva (.CLK(CLK), .RSTN(RSTN), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .SLOW_TICK(SLOW_TICK), .MAIN_TICK(MAIN_TICK), .PLL_A_TICK(PLL_A_TICK),
  .PLL_B_TICK(PLL_B_TICK), .MASTER_TICK(MASTER_TICK), .PROC_TICK(PROC_TICK),
  .PROG_OUT_TICK(PROG_OUT_TICK), .PERIPH_TICK(PERIPH_TICK));

// [testbench/tb_mcs_top.sv]
// self-checking bench for mcs_top: apb tasks and tick counting
// assumes mcs_pkg, the design and its checker are compiled first
`timescale 1ns/1ps
module tb_mcs_top;
  import mcs_pkg::*;
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin mismatches++; \
  $display("CHECK FAILED at %0t got %h exp %h", $time, (a), (b)); end end
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [3:0]  src = 4'h0;
  logic        mtick;
  logic        ptick;
  logic [1:0]  otick;
  logic [16:0] qtick;
  logic [8:0]  tk;
  logic [31:0] rd;
  logic        err;
  logic        meas = 1'b0;
  int          cyc = 0;
  int          cnt[9];
  int          mismatches = 0;
  int          checks_done = 0;
  localparam logic [7:0] RA[8] = '{SYS_CLOCK_STATE_REG_OFF, PERIPH_CLOCK_ST_REG_OFF, PLL_A_CONFIG_OFF,
    PLL_B_CONFIG_OFF, MASTER_CLOCK_CONFIG_OFF, PROG_OUTPUT_CONFIG0_OFF, PROG_OUTPUT_CONFIG1_OFF, POWER_STATUS_REG_OFF};
  localparam logic [31:0] RV[8] = '{32'h1, 32'h0, PLL_CONFIG_RESET, PLL_CONFIG_RESET, 32'h0, 32'h0, 32'h0, 32'h8};
  mcs_top i_dut (.CLK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .SLOW_TICK(src[0]),
    .MAIN_TICK(src[1]), .PLL_A_TICK(src[2]), .PLL_B_TICK(src[3]), .MASTER_TICK(mtick),
    .PROC_TICK(ptick), .PROG_OUT_TICK(otick), .PERIPH_TICK(qtick));
  // counted: master, proc, slow, main, pll a, pll b, prog 0, prog 1, peripheral 4
  assign tk = {qtick[4], otick, src, ptick, mtick};
  always #2.5 clk = ~clk;
  // sources: slow every 40, main every 4, pll a every 2, pll b every 3 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    src <= {cyc % 3 == 0, cyc % 2 == 0, cyc % 4 == 0, cyc % 40 == 0};
    if (meas) begin
      foreach (cnt[i]) cnt[i] += int'(tk[i]);
    end
  end
  // ********
  // tasks
  // ********
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while (pready !== 1'b1 && t < 40);
    if (t == 40) mismatches++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask
  task automatic wait_st(input logic [31:0] m);
    for (int i = 0; i < 200; i++) begin
      apb(1'b0, POWER_STATUS_REG_OFF, 32'h0);
      if ((rd & m) === m) break;
    end
    `CHK(rd & m, m)
  endtask
  task automatic measure(input int n);
    foreach (cnt[i]) cnt[i] = 0;
    meas <= 1'b1;
    repeat (n) @(posedge clk);
    meas <= 1'b0;
    @(posedge clk);
  endtask
  function automatic logic near(input int a, input int b);
    return (a >= b - 1) && (a <= b + 1);
  endfunction
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ********
  // tests
  // ********
  initial begin
    #400000;
    mismatches++;
    end_of_test();
  end
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    foreach (RA[i]) rdc(RA[i], RV[i]);
    measure(400);
    `CHK(near(cnt[0], cnt[2]), 1'b1)
    apb(1'b0, 8'h0c, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
    $display("test reset finished");
    apb(1'b1, PERIPH_CLOCK_SET_REG_OFF, 32'h1_0110);
    rdc(PERIPH_CLOCK_ST_REG_OFF, 32'h1_0110);
    measure(400);
    `CHK(cnt[8], cnt[0])
    apb(1'b1, PERIPH_CLOCK_CLR_REG_OFF, 32'h10);
    rdc(PERIPH_CLOCK_ST_REG_OFF, 32'h1_0100);
    measure(400);
    `CHK(cnt[8], 0)
    $display("test peripheral finished");
    apb(1'b1, MASTER_CLOCK_CONFIG_OFF, 32'h1);
    apb(1'b0, POWER_STATUS_REG_OFF, 32'h0);
    `CHK(rd[3], 1'b0)
    wait_st(32'h8);
    for (int i = 6; i >= 0; i--) begin
      apb(1'b1, MASTER_CLOCK_CONFIG_OFF, 32'h1 | (i << 2));
      apb(1'b0, POWER_STATUS_REG_OFF, 32'h0);
      `CHK(rd[3], 1'b0)
      wait_st(32'h8);
      measure(1024);
      `CHK(near(cnt[0], cnt[3] >> i), 1'b1)
    end
    for (int r = 0; r < 3; r++) begin
      apb(1'b1, MASTER_CLOCK_CONFIG_OFF, 32'h1 | (r << 8));
      measure(400);
      `CHK(near(cnt[0], cnt[1] >> r), 1'b1)
    end
    apb(1'b1, MASTER_CLOCK_CONFIG_OFF, 32'h1);
    $display("test master finished");
    for (int p = 0; p < 2; p++) begin
      apb(1'b1, PLL_A_CONFIG_OFF + 8'(4 * p), 32'h0001_0a00);
      wait_st(32'h2 << p);
      apb(1'b1, MASTER_CLOCK_CONFIG_OFF, 32'h2 + p);
      wait_st(32'h8);
      measure(300);
      `CHK(near(cnt[0], cnt[4 + p]), 1'b1)
      apb(1'b1, PLL_A_CONFIG_OFF + 8'(4 * p), 32'h0001_0a00);
      apb(1'b0, POWER_STATUS_REG_OFF, 32'h0);
      `CHK(rd & (32'h8 | (32'h2 << p)), 32'h0)
      measure(160);
      `CHK(near(cnt[0], cnt[2 + p]), 1'b1)
      wait_st(32'h8 | (32'h2 << p));
      apb(1'b1, MASTER_CLOCK_CONFIG_OFF, 32'h1);
      wait_st(32'h8);
    end
    $display("test pll finished");
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, PROG_OUTPUT_CONFIG0_OFF + 8'(4 * (s % 2)), 32'h4 | s);
      apb(1'b1, SYS_CLOCK_SET_REG_OFF, 32'h100 << (s % 2));
      wait_st(32'h100 << (s % 2));
      rdc(SYS_CLOCK_STATE_REG_OFF, 32'h1 | (32'h100 << (s % 2)));
      measure(400);
      `CHK(near(cnt[6 + s % 2], cnt[2 + s] >> 1), 1'b1)
      apb(1'b1, SYS_CLOCK_CLEAR_REG_OFF, 32'h100 << (s % 2));
      rdc(SYS_CLOCK_STATE_REG_OFF, 32'h1);
      measure(100);
      `CHK(cnt[6 + s % 2], 0)
    end
    $display("test programmable finished");
    end_of_test();
  end
endmodule
